// File: rtl/fss_regs.svh
// constants of the feature settings store
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH

// ==========================================
// feature selector codes and ranges
`define FSS_SEL_RESERVED0    8'h00
`define FSS_SEL_ARBITRATION  8'h01
`define FSS_SEL_LBA_RANGE    8'h03
`define FSS_SEL_WRITE_CACHE  8'h06
`define FSS_SEL_LAST_BASE    8'h0b
`define FSS_SEL_APST         8'h0c
`define FSS_SEL_PROGRESS     8'h80
`define FSS_SEL_HOST_ID      8'h81
`define FSS_SEL_RESV_MASK    8'h82
`define FSS_SEL_RESV_PERSIST 8'h83
`define FSS_SEL_CSS_FIRST    8'h80
`define FSS_SEL_VENDOR_FIRST 8'hc0

// ==========================================
// command dword 10 fields
`define FSS_DW10_SEL_MSB     7
`define FSS_DW10_SEL_LSB     0
`define FSS_DW10_SAVE_BIT    31

// ==========================================
// slot indices and masks
`define FSS_SLOT_CSS_BASE    4'hc
`define FSS_SLOT_ONE         4'h1
`define FSS_FIXED_PERSIST    16'h9004
`define FSS_DEFAULTS         {16{32'h0000_0000}}

// ==========================================
// completion status codes
`define FSS_ST_SUCCESS       8'h00
`define FSS_ST_INVALID_FIELD 8'h02
`define FSS_ST_NOT_SAVEABLE  8'h0d

`endif

// File: rtl/fss_pkg.sv
// types of the feature settings store
package fss_pkg;

    typedef logic [3:0] fss_slot_t;

    typedef struct packed {
        logic [15:0][31:0] cur_vals;
        logic [15:0][31:0] saved_vals;
        logic [15:0]       saved;
        logic              cpl_valid;
        logic [7:0]        cpl_status;
        logic [31:0]       cpl_dw0;
        logic              cpl_use_buffer;
        logic              upd_valid;
        logic [7:0]        upd_selector;
    } fss_state_t;

endpackage

// File: rtl/fss_sel_decode.sv
// feature selector decoder: slot, presence and buffer use
`timescale 1ns/10ps
`include "fss_regs.svh"

module fss_sel_decode (
    input  wire logic [7:0]        selector,
    input  wire logic              opt_lba_range,
    input  wire logic              opt_write_cache,
    input  wire logic              opt_apst,
    input  wire logic              opt_progress_marker,
    input  wire logic              resv_supported,
    input  wire logic              ns_reservation_capability_field_nonzero,
    output      fss_pkg::fss_slot_t slot,
    output      logic              implemented,
    output      logic              uses_buffer
);

    always_comb begin
        slot        = '0;
        implemented = 1'b0;
        uses_buffer = 1'b0;
        // ==========================================
        // base features, 00h and 0dh up reserved
        // identifier space split
        if (selector != `FSS_SEL_RESERVED0 && selector <= `FSS_SEL_APST) begin
            slot = selector[3:0] - `FSS_SLOT_ONE;
            if (selector <= `FSS_SEL_LAST_BASE) begin
                implemented = 1'b1;
            end
            if (selector == `FSS_SEL_LBA_RANGE) begin
                implemented = opt_lba_range;
            end else if (selector == `FSS_SEL_WRITE_CACHE) begin
                implemented = opt_write_cache;
            end else if (selector == `FSS_SEL_APST) begin
                implemented = opt_apst;
            end
        end else if (selector >= `FSS_SEL_CSS_FIRST && selector <= `FSS_SEL_RESV_PERSIST) begin
            slot = `FSS_SLOT_CSS_BASE + {2'b00, selector[1:0]};
            if (selector == `FSS_SEL_PROGRESS) begin
                implemented = opt_progress_marker;
            end else if (selector == `FSS_SEL_HOST_ID) begin
                implemented = resv_supported;
            end else begin
                implemented = ns_reservation_capability_field_nonzero;
            end
        end
        uses_buffer = (selector == `FSS_SEL_LBA_RANGE) || (selector == `FSS_SEL_APST)
                      || (selector == `FSS_SEL_HOST_ID);
    end

endmodule

// File: rtl/fss_store.sv
// feature settings store: set and get of feature values
// ==========================================
// Overview of operation
// - controller reset restores every non-persistent feature to its default, or to its saved value once saved under save support
// - defaults are fixed constants; commands change only current and saved values
// - update lands with its completion, so later commands see it
// - commands in flight may see old or new value
// - 00h and 0dh-7fh reserved, 80h-bfh command set, c0h-ffh implementer
// - 01h,02h,04h,05h,07h-0bh mandatory, non-persistent, dword attributes
// - 03h,06h,0ch optional; 03h persists, others do not
// - 03h, 0ch, 81h move attributes through a memory buffer
// - without save support only 03h, 80h, 83h persist across resets
// - 80h optional; 81h mandatory with reservation support, uses buffer
// - 82h, 83h mandatory when namespace reservation field non-zero
// - implementer features with inactive namespace: implementer's choice
// - selector taken from dword 10 bits 7:0
// - save flag on unsaveable feature aborts with not-saveable status
`timescale 1ns/10ps
`include "fss_regs.svh"

module fss_store (
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    input  wire logic          ctrl_reset,
    input  wire logic          save_supported,
    input  wire logic          resv_supported,
    input  wire logic          ns_reservation_capability_field_nonzero,
    input  wire logic          opt_lba_range,
    input  wire logic          opt_write_cache,
    input  wire logic          opt_apst,
    input  wire logic          opt_progress_marker,
    input  wire logic          cmd_valid,
    input  wire logic          cmd_set,
    input  wire logic          cmd_nsid_active,
    input  wire logic [31:0]   cmd_dw10,
    input  wire logic [31:0]   cmd_dw11,
    output      logic          cpl_valid,
    output      logic [7:0]    cpl_status,
    output      logic [31:0]   cpl_dw0,
    output      logic          cpl_use_buffer,
    output      logic          upd_valid,
    output      logic [7:0]    upd_selector,
    output      logic [511:0]  feat_values,
    output      logic [15:0]   feat_saved
);

    // ==========================================
    // state
    fss_pkg::fss_state_t st_r;
    fss_pkg::fss_state_t st_nxt;

    logic [7:0]          sel;
    logic                save_req;
    fss_pkg::fss_slot_t  slot;
    logic                implemented;
    logic                uses_buffer;
    logic                vendor_sel;
    logic                reject;
    logic                not_saveable;
    logic [511:0]        defaults;
    logic [15:0]         fixed_persist;

    assign sel      = cmd_dw10[`FSS_DW10_SEL_MSB:`FSS_DW10_SEL_LSB];
    assign save_req = cmd_dw10[`FSS_DW10_SAVE_BIT];
    assign defaults = `FSS_DEFAULTS;
    // a literal cannot be indexed, so the mask lives on a net
    assign fixed_persist = `FSS_FIXED_PERSIST;

    fss_sel_decode u_decode (
        .selector            (sel),
        .opt_lba_range       (opt_lba_range),
        .opt_write_cache     (opt_write_cache),
        .opt_apst            (opt_apst),
        .opt_progress_marker (opt_progress_marker),
        .resv_supported      (resv_supported),
        .ns_reservation_capability_field_nonzero   (ns_reservation_capability_field_nonzero),
        .slot                (slot),
        .implemented         (implemented),
        .uses_buffer         (uses_buffer)
    );

    // inactive namespace on implementer range refused
    assign vendor_sel   = (sel >= `FSS_SEL_VENDOR_FIRST);
    // reserved and implementer codes hold no slot
    assign reject       = !implemented || (vendor_sel && !cmd_nsid_active);
    // nothing is saveable without save support
    assign not_saveable = cmd_set && save_req && !save_supported;

    // ==========================================
    // next state
    always_comb begin
        st_nxt           = st_r;
        st_nxt.cpl_valid = 1'b0;
        st_nxt.upd_valid = 1'b0;
        if (ctrl_reset) begin
            // controller reset drops any command of the same cycle
            for (int i = 0; i < 16; i++) begin
                if (save_supported) begin
                    st_nxt.cur_vals[i] = st_r.saved[i] ? st_r.saved_vals[i]
                                                       : defaults[i*32 +: 32];
                end else if (!fixed_persist[i]) begin
                    st_nxt.cur_vals[i] = defaults[i*32 +: 32];
                end
            end
        end else if (cmd_valid) begin
            st_nxt.cpl_valid      = 1'b1;
            st_nxt.cpl_dw0        = '0;
            st_nxt.cpl_use_buffer = 1'b0;
            if (reject) begin
                st_nxt.cpl_status = `FSS_ST_INVALID_FIELD;
            end else if (not_saveable) begin
                st_nxt.cpl_status = `FSS_ST_NOT_SAVEABLE;
            end else begin
                st_nxt.cpl_status     = `FSS_ST_SUCCESS;
                st_nxt.cpl_use_buffer = uses_buffer;
                if (cmd_set) begin
                    // in-flight users may sample either side
                    st_nxt.cur_vals[slot] = cmd_dw11;
                    st_nxt.upd_valid      = 1'b1;
                    st_nxt.upd_selector   = sel;
                    if (save_req) begin
                        st_nxt.saved_vals[slot] = cmd_dw11;
                        st_nxt.saved[slot]      = 1'b1;
                    end
                end else begin
                    st_nxt.cpl_dw0 = st_r.cur_vals[slot];
                end
            end
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_r.cur_vals       <= `FSS_DEFAULTS;
            st_r.saved_vals     <= `FSS_DEFAULTS;
            st_r.saved          <= '0;
            st_r.cpl_valid      <= 1'b0;
            st_r.cpl_status     <= `FSS_ST_SUCCESS;
            st_r.cpl_dw0        <= '0;
            st_r.cpl_use_buffer <= 1'b0;
            st_r.upd_valid      <= 1'b0;
            st_r.upd_selector   <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // outputs, all straight from the state
    assign cpl_valid      = st_r.cpl_valid;
    assign cpl_status     = st_r.cpl_status;
    assign cpl_dw0        = st_r.cpl_dw0;
    assign cpl_use_buffer = st_r.cpl_use_buffer;
    assign upd_valid      = st_r.upd_valid;
    assign upd_selector   = st_r.upd_selector;
    assign feat_values    = st_r.cur_vals;
    assign feat_saved     = st_r.saved;

endmodule

// File: tb/fss_store_monitor.sv
// checker of the feature settings store ports
`timescale 1ns/10ps
module fss_store_chk (
    input wire logic         ref_clk,
    input wire logic         rst_b,
    input wire logic         ctrl_reset,
    input wire logic         save_supported,
    input wire logic         opt_apst,
    input wire logic         cmd_valid,
    input wire logic         cmd_set,
    input wire logic [31:0]  cmd_dw10,
    input wire logic         cpl_valid,
    input wire logic [7:0]   cpl_status,
    input wire logic         cpl_use_buffer,
    input wire logic         upd_valid,
    input wire logic [511:0] feat_values
);
    // ====================
    // command acceptance and controller reset
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_take(sel);
        cmd_valid && !ctrl_reset && cmd_dw10[7:0] == sel;
    endsequence
    a_cpl_follows: assert property (cmd_valid && !ctrl_reset |=> cpl_valid)
        else $error("no completion after command");
    a_no_stray: assert property (!cmd_valid || ctrl_reset |=> !cpl_valid)
        else $error("completion without command");
    a_upd_with_cpl: assert property (upd_valid |-> cpl_valid && cpl_status == 8'h00)
        else $error("update pulse without good completion");
    a_zero_invalid: assert property (s_take(8'h00) |=> cpl_status == 8'h02 && !upd_valid)
        else $error("reserved selector accepted");
    a_vendor_invalid: assert property (cmd_valid && !ctrl_reset && cmd_dw10[7:6] == 2'b11
        |=> cpl_status == 8'h02) else $error("implementer selector accepted");
    a_mand_good: assert property (s_take(8'h05) ##0 !cmd_set |=> cpl_status == 8'h00)
        else $error("mandatory get refused");
    a_not_saveable: assert property (s_take(8'h01) ##0 cmd_set && cmd_dw10[31]
        && !save_supported |=> cpl_status == 8'h0d) else $error("save flag not refused");
    a_buffer_used: assert property (s_take(8'h0c) ##0 opt_apst
        && !(cmd_set && cmd_dw10[31] && !save_supported) |=> cpl_use_buffer)
        else $error("buffer flag missing");
    a_reset_clear: assert property (ctrl_reset && !save_supported
        |=> feat_values[31:0] == 32'h0) else $error("value kept over reset");
    a_keep_persist: assert property (ctrl_reset && !save_supported
        |=> $stable(feat_values[95:64])) else $error("persistent value lost");
endmodule

bind fss_store fss_store_chk u_chk (.ref_clk, .rst_b, .ctrl_reset, .save_supported,
    .opt_apst, .cmd_valid, .cmd_set, .cmd_dw10, .cpl_valid, .cpl_status,
    .cpl_use_buffer, .upd_valid, .feat_values);

// File: tb/fss_host.sv
// host side model issuing feature commands
`timescale 1ns/10ps
module fss_host (
    input  wire logic        ref_clk,
    output      logic        cmd_valid = 1'b0,
    output      logic        cmd_set = 1'b0,
    output      logic        cmd_nsid_active = 1'b1,
    output      logic [31:0] cmd_dw10 = 32'h0,
    output      logic [31:0] cmd_dw11 = 32'h0
);
    // one command at a time, answer awaited
    task automatic send(input logic s, input logic [31:0] d10, input logic [31:0] d11);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_set   <= s;
        cmd_dw10  <= d10;
        cmd_dw11  <= d11;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        // released lines must not show stale data
        cmd_dw10  <= ~d10;
        cmd_dw11  <= ~d11;
        #1;
    endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench of the feature settings store
`timescale 1ns/10ps
module tb_top;
    logic         ref_clk;
    logic         rst_b = 1'b0;
    logic         ctrl_reset = 1'b0;
    logic [6:0]   cfg = 7'h0;
    logic         cmd_valid, cmd_set, cmd_nsid_active, cpl_valid, cpl_use_buffer, upd_valid;
    logic [31:0]  cmd_dw10, cmd_dw11, cpl_dw0;
    logic [7:0]   cpl_status, upd_selector;
    logic [511:0] feat_values;
    logic [15:0]  feat_saved;
    int           errors, total_checks, cycles;

    fss_host u_host (.ref_clk, .cmd_valid, .cmd_set, .cmd_nsid_active, .cmd_dw10, .cmd_dw11);
    fss_store u_dut (.ref_clk, .rst_b, .ctrl_reset, .save_supported(cfg[0]),
        .resv_supported(cfg[1]), .ns_reservation_capability_field_nonzero(cfg[2]), .opt_lba_range(cfg[3]),
        .opt_write_cache(cfg[4]), .opt_apst(cfg[5]), .opt_progress_marker(cfg[6]),
        .cmd_valid, .cmd_set, .cmd_nsid_active, .cmd_dw10, .cmd_dw11, .cpl_valid,
        .cpl_status, .cpl_dw0, .cpl_use_buffer, .upd_valid, .upd_selector,
        .feat_values, .feat_saved);

    // ====================
    // helpers
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmd(input logic s, input logic [7:0] sel, input logic [31:0] v,
                       input logic sv = 1'b0);
        u_host.send(s, {sv, 23'h0, sel}, v);
        check("completion", 1, cpl_valid);
    endtask
    task automatic set_cfg(input logic [6:0] c);
        @(posedge ref_clk);
        cfg <= c;
    endtask
    task automatic pulse_reset;
        @(posedge ref_clk);
        ctrl_reset <= 1'b1;
        @(posedge ref_clk);
        ctrl_reset <= 1'b0;
        #1;
    endtask

    // ====================
    // scenarios
    task automatic t_mandatory;
        logic [7:0] m[9] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b};
        foreach (m[i]) begin
            cmd(1, m[i], {24'h5a5a00, m[i]});
            check("set status", 8'h00, cpl_status);
            check("update pulse", 1, upd_valid);
            check("update selector", m[i], upd_selector);
            cmd(0, m[i], 32'h0);
            check("get value", {24'h5a5a00, m[i]}, cpl_dw0);
            check("buffer flag", 0, cpl_use_buffer);
        end
    endtask
    task automatic t_invalid;
        logic [7:0] r[14] = '{8'h00, 8'h0d, 8'h7f, 8'h84, 8'hbf, 8'hc0, 8'hff,
                              8'h03, 8'h06, 8'h0c, 8'h80, 8'h81, 8'h82, 8'h83};
        foreach (r[i]) begin
            cmd(1, r[i], 32'hffff_ffff);
            check("refused status", 8'h02, cpl_status);
            check("no update", 0, upd_valid);
        end
        u_host.cmd_nsid_active <= 1'b0;
        cmd(0, 8'hc0, 32'h0);
        check("inactive ns status", 8'h02, cpl_status);
        u_host.cmd_nsid_active <= 1'b1;
        check("slot 0 kept", 32'h5a5a0001, feat_values[31:0]);
    endtask
    task automatic t_optional;
        logic [7:0] o[7] = '{8'h03, 8'h06, 8'h0c, 8'h80, 8'h81, 8'h82, 8'h83};
        set_cfg(7'h7e);
        foreach (o[i]) begin
            cmd(1, o[i], {24'hc3c3c3, o[i]});
            check("optional set", 8'h00, cpl_status);
            cmd(0, o[i], 32'h0);
            check("optional get", {24'hc3c3c3, o[i]}, cpl_dw0);
            check("buffer flag", o[i] == 8'h03 || o[i] == 8'h0c || o[i] == 8'h81,
                  cpl_use_buffer);
        end
    endtask
    task automatic t_ctrl;
        pulse_reset();
        check("slot 01h", 32'h0, feat_values[31:0]);
        check("slot 06h", 32'h0, feat_values[191:160]);
        check("slot 0ch", 32'h0, feat_values[383:352]);
        check("slot 81h", 32'h0, feat_values[447:416]);
        check("slot 03h", 32'hc3c3c303, feat_values[95:64]);
        check("slot 80h", 32'hc3c3c380, feat_values[415:384]);
        check("slot 83h", 32'hc3c3c383, feat_values[511:480]);
    endtask
    task automatic t_save;
        cmd(1, 8'h01, 32'h1111_2222, 1);
        check("unsaveable", 8'h0d, cpl_status);
        check("slot 01h", 32'h0, feat_values[31:0]);
        set_cfg(7'h7f);
        cmd(1, 8'h01, 32'h1234_abcd, 1);
        check("saved bit", 1, feat_saved[0]);
        cmd(1, 8'h01, 32'h0000_beef);
        pulse_reset();
        check("saved copy", 32'h1234_abcd, feat_values[31:0]);
    endtask

    // ====================
    // run control
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // bound well above the roughly 120 cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_mandatory();
        t_invalid();
        t_optional();
        t_ctrl();
        set_cfg(7'h00);
        t_save();
        give_verdict();
    end
endmodule
